// file: logic/rcs_pkg.sv
// Purpose: shared constants and types for the reset and clock source control
// Assumes: system clock of 50 MHz
// Notes:   cause bit positions and select codes used by the controller
package rcs_pkg;

  // ****************************************************************
  // sizes and timing
  // ****************************************************************
  localparam int          PERIPH_REGS  = 3;
  localparam int          PERIPH_BITS  = 32;
  localparam int          WDT_W        = 32;
  localparam int          CLK_MHZ      = 50;
  localparam int          SW_RST_NS    = 100;
  localparam int          SW_RST_CYC   = (SW_RST_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  SW_RST_LOAD  = SW_RST_CYC[3:0];

  // ****************************************************************
  // reset cause layout
  // ****************************************************************
  localparam int          CAUSE_W      = 5;
  localparam int          CAUSE_EXT    = 0;
  localparam int          CAUSE_POR    = 1;
  localparam int          CAUSE_BOR    = 2;
  localparam int          CAUSE_WDT    = 3;
  localparam int          CAUSE_SW     = 4;
  localparam logic [4:0]  CAUSE_RST    = 5'h02;

  // ****************************************************************
  // clock selection
  // ****************************************************************
  localparam logic [1:0]  OSC_MAIN     = 2'h0;
  localparam logic [1:0]  OSC_INT      = 2'h1;
  localparam logic [1:0]  OSC_INT_DIV4 = 2'h2;
  localparam logic [1:0]  OSC_30K      = 2'h3;
  localparam logic        PLL_SKIP_RST = 1'h1;

  typedef enum logic [2:0] {
    SRC_MAIN     = 3'h0,
    SRC_INT      = 3'h1,
    SRC_INT_DIV4 = 3'h2,
    SRC_30K      = 3'h3,
    SRC_PLL      = 3'h4
  } rcs_clk_src_t;

  // ****************************************************************
  // regulator: code 0 is 2250 mV, 50 mV a step, code 10 is 2750 mV
  // ****************************************************************
  localparam int          REGULATOR_VOLTAGE_ADJUST_MIN_MV  = 2250;
  localparam int          REGULATOR_VOLTAGE_ADJUST_STEP_MV = 50;
  localparam logic [3:0]  REGULATOR_VOLTAGE_ADJUST_MAX     = 4'hA;
  localparam logic [3:0]  REGULATOR_VOLTAGE_ADJUST_RST     = 4'h5;

  // ****************************************************************
  // core boot steps
  // ****************************************************************
  typedef enum logic [2:0] {
    BT_HOLD  = 3'h0,
    BT_SP    = 3'h1,
    BT_PC    = 3'h2,
    BT_INSTR = 3'h3,
    BT_RUN   = 3'h4
  } rcs_boot_t;

endpackage

// file: logic/rcs_wdog_if.sv
// Purpose: carrier between the controller and its watchdog
// Assumes: both ends on the system clock
// Notes:   none
interface rcs_wdog_if;
  logic [31:0] load;
  logic        enable;
  logic        reset_en;
  logic        irq_clear;
  logic        srst;
  logic        irq;
  logic        reset_req;

  modport ctrl (output load, enable, reset_en, irq_clear, srst, input irq, reset_req);
  modport wdog (input load, enable, reset_en, irq_clear, srst, output irq, reset_req);
endinterface

// file: logic/rcs_watchdog.sv
// Purpose: two-stage watchdog, interrupt first, reset request second
// Assumes: load value stable while counting
// Notes:   reset_req is a one-cycle pulse
module rcs_watchdog (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // controller side
  rcs_wdog_if.wdog  w
);

  logic [rcs_pkg::WDT_W-1:0] cnt_q;
  logic                      irq_q;
  logic                      req_q;
  logic                      zero;

  assign zero        = (cnt_q == '0);
  assign w.irq       = irq_q;
  assign w.reset_req = req_q;

  // ****************************************************************
  // down-counter
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '1;
    end else if (ce) begin
      if (!w.enable || w.srst || zero) begin
        cnt_q <= w.load; // R11
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // ****************************************************************
  // first time-out flag, set wins over clear
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      if (w.srst || !w.enable) begin
        irq_q <= 1'b0;
      end else if (zero) begin
        irq_q <= 1'b1; // R10
      end else if (w.irq_clear) begin
        irq_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // second time-out reset request
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
    end else if (ce) begin
      req_q <= w.enable && !w.srst && zero && irq_q && w.reset_en; // R12
    end
  end

  a_wdt_second: assert property (@(posedge clk) disable iff (!reset_n) // R12
    req_q |-> $past(irq_q) && $past(w.reset_en) && $past(zero))
    else $error("watchdog reset without pending first time-out");

  a_wdt_reload: assert property (@(posedge clk) disable iff (!reset_n) // R11
    ce && w.enable && !w.srst && zero |=> cnt_q == $past(w.load))
    else $error("watchdog did not reload after time-out");

  a_wdt_first: assert property (@(posedge clk) disable iff (!reset_n) // R10
    ce && w.enable && !w.srst && zero && !irq_q |=> irq_q && !req_q)
    else $error("first time-out did not raise interrupt only");

endmodule

// file: logic/rcs_reset_clock_ctrl.sv
// Purpose: reset gathering, reset outputs and system clock source choice
// Assumes: all inputs synchronous to clk; reset_n is power-on reset
// Notes:   clock choice is a select code for the clock mux outside
//
// Summary of operation
// R1: brown-out reset starts disabled, software enables
// R2: brown-out gives interrupt, or reset when enabled
// R3: brown-out reset held while condition lasts
// R4: cause register records brown-out
// R5: peripheral reset while its bit is set
// R6: reset bits match clock-gating bit positions
// R7: one reset covers all unit clock domains
// R8: system request asserts then releases reset
// R9: core fetches stack, counter, instruction, runs
// R10: watchdog interrupts first, resets on second
// R11: watchdog reloads after first time-out
// R12: watchdog reset needs pending interrupt and enable
// R13: regulator set 2.25 V to 2.75 V
// R14: internal oscillator selected at power-on
// R15: software stabilises main oscillator before switching
// R16: PLL and internal divide-by-four also selectable
// R17: bypass uses oscillator source code
// R18: PLL only from main oscillator source
// R19: 30 kHz oscillator for deep sleep
// R20: software keeps PLL reference within range
// R21: causes sticky; power-on clears all others
// R22: peripheral reset leaves core running
// R23: reset releases synchronised to system clock
module rcs_reset_clock_ctrl #(
  parameter int PERIPH_REGS = rcs_pkg::PERIPH_REGS,
  parameter int PERIPH_BITS = rcs_pkg::PERIPH_BITS
) (
  // clock and power-on reset
  input  wire  logic                                   clk,
  input  wire  logic                                   reset_n,
  input  wire  logic                                   ce,
  // reset sources
  input  wire  logic                                   ext_reset_n,
  input  wire  logic                                   brownout_detect,
  input  wire  logic                                   sys_reset_req,
  // brown-out control
  input  wire  logic                                   bor_ctrl_wr,
  input  wire  logic                                   bor_reset_en_wdata,
  input  wire  logic                                   bor_irq_clr,
  // reset cause clearing
  input  wire  logic                                   cause_clr_wr,
  input  wire  logic [rcs_pkg::CAUSE_W-1:0]            cause_clr_mask,
  // peripheral reset and gating
  input  wire  logic [PERIPH_REGS-1:0]                 periph_rst_wr,
  input  wire  logic [PERIPH_BITS-1:0]                 periph_rst_wdata,
  input  wire  logic [PERIPH_REGS-1:0][PERIPH_BITS-1:0] periph_clk_gate,
  // watchdog control
  input  wire  logic [rcs_pkg::WDT_W-1:0]              wdt_load,
  input  wire  logic                                   wdt_enable,
  input  wire  logic                                   wdt_reset_en,
  input  wire  logic                                   wdt_irq_clear,
  // regulator control
  input  wire  logic                                   ldo_wr,
  input  wire  logic [3:0]                             ldo_regulator_voltage_adjust_wdata,
  // clock configuration
  input  wire  logic                                   clk_cfg_wr,
  input  wire  logic [1:0]                             osc_src_wdata,
  input  wire  logic                                   pll_skip_wdata,
  input  wire  logic                                   main_osc_en_wdata,
  input  wire  logic                                   deep_sleep,
  // core boot
  input  wire  logic                                   core_fetch_ack,
  // reset outputs
  output logic                                         core_reset_n_q,
  output logic [PERIPH_REGS-1:0][PERIPH_BITS-1:0]      periph_reset_n_q,
  output logic [PERIPH_REGS-1:0][PERIPH_BITS-1:0]      periph_clk_en_q,
  // status
  output logic                                         bor_reset_en_q,
  output logic                                         bor_irq_q,
  output logic [rcs_pkg::CAUSE_W-1:0]                  reset_cause_q,
  output logic                                         wdt_irq_q,
  // regulator and clock outputs
  output logic [3:0]                                   regulator_voltage_adjust_q,
  output rcs_pkg::rcs_clk_src_t                        system_clock_src_q,
  output logic                                         pll_ref_main_q,
  output logic                                         main_osc_pwr_q,
  // boot sequence
  output rcs_pkg::rcs_boot_t                           boot_step_q,
  output logic                                         core_run_q
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (PERIPH_REGS < 1 || PERIPH_REGS > 8) begin : g_chk_regs
    $error("PERIPH_REGS out of range");
  end
  if (PERIPH_BITS < 1 || PERIPH_BITS > 32) begin : g_chk_bits
    $error("PERIPH_BITS out of range");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  rcs_wdog_if                            wd ();
  logic [3:0]                            hold_q;
  logic                                  rel_q;
  logic                                  rst_cond;
  logic                                  bor_rst;
  logic [PERIPH_REGS-1:0][PERIPH_BITS-1:0] srcr_q;
  logic [1:0]                            osc_src_q;
  logic                                  pll_skip_q;
  logic                                  main_osc_en_q;
  logic                                  pll_ok;
  rcs_pkg::rcs_clk_src_t                 src_d;
  rcs_pkg::rcs_boot_t                    boot_d;
  logic [rcs_pkg::CAUSE_W-1:0]           cause_set;

  // ****************************************************************
  // watchdog
  // ****************************************************************
  assign wd.load      = wdt_load;
  assign wd.enable    = wdt_enable;
  assign wd.reset_en  = wdt_reset_en;
  assign wd.irq_clear = wdt_irq_clear;
  assign wd.srst      = !core_reset_n_q;

  rcs_watchdog u_wdog (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .w       (wd.wdog)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_irq_q <= 1'b0;
    end else if (ce) begin
      wdt_irq_q <= wd.irq; // R10
    end
  end

  // ****************************************************************
  // brown-out control and interrupt
  // ****************************************************************
  assign bor_rst = brownout_detect && bor_reset_en_q; // R2

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bor_reset_en_q <= 1'b0; // R1
    end else if (ce && bor_ctrl_wr) begin
      bor_reset_en_q <= bor_reset_en_wdata; // R1
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bor_irq_q <= 1'b0;
    end else if (ce) begin
      if (brownout_detect && !bor_reset_en_q) begin
        bor_irq_q <= 1'b1; // R2
      end else if (bor_irq_clr) begin
        bor_irq_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // internal reset gathering and synchronised release
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 4'h0;
    end else if (ce) begin
      if (sys_reset_req || wd.reset_req) begin
        hold_q <= rcs_pkg::SW_RST_LOAD; // R8
      end else if (hold_q != 4'h0) begin
        hold_q <= hold_q - 4'h1;
      end
    end
  end

  assign rst_cond = !ext_reset_n || bor_rst || (hold_q != 4'h0) // R3
                    || sys_reset_req || wd.reset_req;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_q          <= 1'b0;
      core_reset_n_q <= 1'b0;
    end else if (ce) begin
      rel_q          <= !rst_cond; // R23
      core_reset_n_q <= rel_q && !rst_cond; // R8
    end
  end

  // ****************************************************************
  // reset cause
  // ****************************************************************
  always_comb begin
    cause_set                     = '0;
    cause_set[rcs_pkg::CAUSE_EXT] = !ext_reset_n;
    cause_set[rcs_pkg::CAUSE_BOR] = bor_rst; // R4
    cause_set[rcs_pkg::CAUSE_WDT] = wd.reset_req;
    cause_set[rcs_pkg::CAUSE_SW]  = sys_reset_req;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_cause_q <= rcs_pkg::CAUSE_RST; // R21
    end else if (ce) begin
      if (cause_clr_wr) begin
        reset_cause_q <= (reset_cause_q & ~cause_clr_mask) | cause_set;
      end else begin
        reset_cause_q <= reset_cause_q | cause_set; // R21
      end
    end
  end

  // ****************************************************************
  // peripheral software resets
  // ****************************************************************
  for (genvar r = 0; r < PERIPH_REGS; r++) begin : g_reg
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        srcr_q[r] <= '0;
      end else if (ce) begin
        if (!core_reset_n_q) begin
          srcr_q[r] <= '0;
        end else if (periph_rst_wr[r]) begin
          srcr_q[r] <= periph_rst_wdata; // R5
        end
      end
    end

    for (genvar b = 0; b < PERIPH_BITS; b++) begin : g_bit
      // one reset line drives every clock domain of the unit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          periph_reset_n_q[r][b] <= 1'b0;
          periph_clk_en_q[r][b]  <= 1'b0;
        end else if (ce) begin
          periph_reset_n_q[r][b] <= rel_q && !rst_cond && !srcr_q[r][b]; // R5 R7 R22 R23
          periph_clk_en_q[r][b]  <= periph_clk_gate[r][b]; // R6
        end
      end
    end
  end

  // ****************************************************************
  // regulator adjust
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regulator_voltage_adjust_q <= rcs_pkg::REGULATOR_VOLTAGE_ADJUST_RST;
    end else if (ce && ldo_wr && ldo_regulator_voltage_adjust_wdata <= rcs_pkg::REGULATOR_VOLTAGE_ADJUST_MAX) begin
      regulator_voltage_adjust_q <= ldo_regulator_voltage_adjust_wdata; // R13
    end
  end

  // ****************************************************************
  // clock source configuration
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_src_q     <= rcs_pkg::OSC_INT; // R14
      pll_skip_q    <= rcs_pkg::PLL_SKIP_RST;
      main_osc_en_q <= 1'b0;
    end else if (ce && clk_cfg_wr) begin
      osc_src_q     <= osc_src_wdata;
      pll_skip_q    <= pll_skip_wdata;
      main_osc_en_q <= main_osc_en_wdata;
    end
  end

  assign pll_ok = !pll_skip_q && osc_src_q == rcs_pkg::OSC_MAIN;

  always_comb begin
    src_d = rcs_pkg::SRC_INT;
    if (deep_sleep) begin
      src_d = rcs_pkg::SRC_30K; // R19
    end else if (pll_ok) begin
      src_d = rcs_pkg::SRC_PLL; // R18
    end else begin
      unique case (osc_src_q) // R17
        rcs_pkg::OSC_MAIN:     src_d = rcs_pkg::SRC_MAIN;
        rcs_pkg::OSC_INT:      src_d = rcs_pkg::SRC_INT;
        rcs_pkg::OSC_INT_DIV4: src_d = rcs_pkg::SRC_INT_DIV4; // R16
        rcs_pkg::OSC_30K:      src_d = rcs_pkg::SRC_30K;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      system_clock_src_q   <= rcs_pkg::SRC_INT; // R14
      pll_ref_main_q <= 1'b0;
      main_osc_pwr_q <= 1'b0;
    end else if (ce) begin
      system_clock_src_q   <= src_d; // R16
      pll_ref_main_q <= pll_ok && !deep_sleep; // R18
      main_osc_pwr_q <= main_osc_en_q && !deep_sleep; // R19
    end
  end

  // ****************************************************************
  // core boot sequence
  // ****************************************************************
  always_comb begin
    boot_d = boot_step_q;
    unique case (boot_step_q)
      rcs_pkg::BT_HOLD:  boot_d = rcs_pkg::BT_SP;
      rcs_pkg::BT_SP:    if (core_fetch_ack) boot_d = rcs_pkg::BT_PC;
      rcs_pkg::BT_PC:    if (core_fetch_ack) boot_d = rcs_pkg::BT_INSTR;
      rcs_pkg::BT_INSTR: if (core_fetch_ack) boot_d = rcs_pkg::BT_RUN;
      rcs_pkg::BT_RUN:   boot_d = rcs_pkg::BT_RUN;
      default:           boot_d = rcs_pkg::BT_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_step_q <= rcs_pkg::BT_HOLD;
      core_run_q  <= 1'b0;
    end else if (ce) begin
      if (!core_reset_n_q) begin
        boot_step_q <= rcs_pkg::BT_HOLD;
        core_run_q  <= 1'b0;
      end else begin
        boot_step_q <= boot_d; // R9
        core_run_q  <= boot_d == rcs_pkg::BT_RUN;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_fetch_step(rcs_pkg::rcs_boot_t from_st);
    ce && core_reset_n_q && core_fetch_ack && boot_step_q == from_st;
  endsequence

  sequence s_next_step(rcs_pkg::rcs_boot_t to_st);
    ##1 boot_step_q == to_st;
  endsequence

  a_bor_held: assert property (ce && bor_rst |=> !core_reset_n_q) // R3
    else $error("brown-out did not hold reset");
  a_bor_irq: assert property (ce && brownout_detect && !bor_reset_en_q |=> bor_irq_q) // R2
    else $error("brown-out interrupt missing");
  a_bor_cause: assert property (ce && bor_rst |=> reset_cause_q[rcs_pkg::CAUSE_BOR]) // R4
    else $error("brown-out cause not recorded");
  a_bor_noreset: assert property (ce && brownout_detect && !bor_reset_en_q // R2
    && ext_reset_n && hold_q == 4'h0 && !sys_reset_req && !wd.reset_req
    && rel_q |=> core_reset_n_q)
    else $error("disabled brown-out caused reset");
  a_cause_sticky: assert property (ce && !cause_clr_wr |=> // R21
    (reset_cause_q & $past(reset_cause_q)) == $past(reset_cause_q))
    else $error("reset cause bit lost");
  a_periph_map: assert property (ce && rel_q && !rst_cond |=> // R5
    periph_reset_n_q == ~$past(srcr_q))
    else $error("peripheral reset does not follow its bit");
  a_gate_map: assert property (ce |=> periph_clk_en_q == $past(periph_clk_gate)) // R6
    else $error("gate bit position mismatch");
  a_sw_hold: assert property (ce && sys_reset_req |=> !core_reset_n_q ##1 // R8
    (!ce || !core_reset_n_q))
    else $error("system request reset not asserted");
  a_sync_release: assert property ($rose(core_reset_n_q) |-> // R23
    $past(rel_q) && periph_reset_n_q == ~$past(srcr_q))
    else $error("reset releases not on one edge");
  a_boot_pc: assert property (s_fetch_step(rcs_pkg::BT_SP) |-> // R9
    s_next_step(rcs_pkg::BT_PC))
    else $error("boot did not fetch counter after stack");
  a_boot_run: assert property (s_fetch_step(rcs_pkg::BT_INSTR) |-> // R9
    s_next_step(rcs_pkg::BT_RUN) ##0 core_run_q)
    else $error("boot did not start running");
  a_pll_main: assert property (system_clock_src_q == rcs_pkg::SRC_PLL |-> $past(pll_ok)) // R18
    else $error("PLL selected without main oscillator");
  a_regulator_voltage_adjust_range: assert property (regulator_voltage_adjust_q <= rcs_pkg::REGULATOR_VOLTAGE_ADJUST_MAX) // R13
    else $error("regulator code out of range");

endmodule

// file: bench/rcs_core_model.sv
// Purpose: core model answering the boot fetch steps
// Assumes: boot_step_q advances on each acknowledge
// Notes:   slow sets wait cycles before each acknowledge
module rcs_core_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // boot handshake
  input  wire rcs_pkg::rcs_boot_t boot_step_q,
  input  wire logic [3:0]         slow,
  output logic                    core_fetch_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] done_q;
  logic [3:0] wait_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_fetch_ack <= 1'h0;
      done_q         <= 3'h0;
      wait_q         <= 4'h0;
    end else if (core_fetch_ack) begin
      core_fetch_ack <= 1'h0;
      done_q         <= boot_step_q;
      wait_q         <= 4'h0;
    end else if (boot_step_q == rcs_pkg::BT_HOLD) begin
      done_q <= 3'h0;
    end else if (boot_step_q != rcs_pkg::BT_RUN && boot_step_q != done_q) begin
      if (wait_q >= slow) begin
        core_fetch_ack <= 1'h1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// file: bench/tb.sv
// Purpose: self-checking bench for the reset and clock source control
// Assumes: inputs driven 2 ns after the rising edge
// Notes:   random data from a bench shift register
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, ce, ext_reset_n, brownout_detect, sys_reset_req, bor_ctrl_wr;
  logic bor_reset_en_wdata, bor_irq_clr, cause_clr_wr, wdt_enable, wdt_reset_en;
  logic wdt_irq_clear, ldo_wr, clk_cfg_wr, pll_skip_wdata, main_osc_en_wdata, deep_sleep;
  logic core_fetch_ack, core_reset_n_q, bor_reset_en_q, bor_irq_q, wdt_irq_q;
  logic pll_ref_main_q, main_osc_pwr_q, core_run_q;
  logic [4:0] cause_clr_mask, reset_cause_q;
  logic [2:0] periph_rst_wr;
  logic [31:0] periph_rst_wdata, wdt_load, rnd;
  logic [2:0][31:0] periph_clk_gate, periph_reset_n_q, periph_clk_en_q;
  logic [3:0] ldo_regulator_voltage_adjust_wdata, regulator_voltage_adjust_q, slow;
  logic [1:0] osc_src_wdata;
  rcs_pkg::rcs_clk_src_t system_clock_src_q;
  rcs_pkg::rcs_boot_t boot_step_q;
  int errors, cmp_count;
  rcs_reset_clock_ctrl u_rcs_reset_clock_ctrl (.*);
  rcs_core_model u_rcs_core_model (.*);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait: 0 core running, 1 core in reset, 2 watchdog interrupt
  task automatic wait_on(input int k);
    for (int i = 0; i < 300; i++) begin
      if ((k == 0 && core_run_q === 1'h1) || (k == 1 && core_reset_n_q === 1'h0)
          || (k == 2 && wdt_irq_q === 1'h1)) return;
      cyc(1);
    end
    errors++;
    tally_and_finish();
  endtask
  initial begin
    {ce, ext_reset_n, rnd, slow} = {2'h3, 32'h376FE1F7, 4'h0};
    {reset_n, brownout_detect, sys_reset_req, bor_ctrl_wr, bor_reset_en_wdata} = '0;
    {bor_irq_clr, cause_clr_wr, cause_clr_mask, periph_rst_wr, periph_rst_wdata} = '0;
    {periph_clk_gate, wdt_load, wdt_enable, wdt_reset_en, wdt_irq_clear} = '0;
    {ldo_wr, ldo_regulator_voltage_adjust_wdata, clk_cfg_wr, osc_src_wdata, main_osc_en_wdata} = '0;
    {pll_skip_wdata, deep_sleep} = 2'h2;
    cyc(8);
    chk({core_reset_n_q, bor_reset_en_q, reset_cause_q}, {2'h0, 5'h02});
    chk({system_clock_src_q, regulator_voltage_adjust_q}, {3'h1, 4'h5});
    reset_n = 1'h1;
    wait_on(0);
    chk(boot_step_q, rcs_pkg::BT_RUN);
    $display("test reset done");
    brownout_detect = 1'h1;
    cyc(3);
    chk({bor_irq_q, core_reset_n_q}, 2'h3);
    {brownout_detect, bor_irq_clr, bor_ctrl_wr, bor_reset_en_wdata, slow} = {4'h7, 4'h3};
    cyc(1);
    {bor_irq_clr, bor_ctrl_wr, brownout_detect} = 3'h1;
    cyc(12);
    chk({bor_reset_en_q, core_reset_n_q, reset_cause_q[2]}, 3'h5);
    brownout_detect = 1'h0;
    wait_on(0);
    $display("test brown-out done");
    for (int r = 0; r < 3; r++) begin
      rnd = lfsr(rnd);
      {periph_rst_wr, periph_rst_wdata} = {3'h1 << r, rnd};
      periph_clk_gate[r] = ~rnd;
      cyc(2);
      chk(periph_reset_n_q[r], ~rnd);
      chk(periph_clk_en_q[r], ~rnd);
      chk(core_reset_n_q, 1'h1);
      periph_rst_wdata = 32'h0;
      cyc(2);
      chk(periph_reset_n_q[r], 32'hFFFFFFFF);
      periph_rst_wr = 3'h0;
    end
    $display("test peripheral reset done");
    sys_reset_req = 1'h1;
    cyc(1);
    sys_reset_req = 1'h0;
    chk({core_reset_n_q, reset_cause_q[4], reset_cause_q[2]}, 3'h3);
    cyc(1);
    wait_on(0);
    {ext_reset_n, cause_clr_wr, cause_clr_mask} = 7'h3F;
    cyc(2);
    {ext_reset_n, cause_clr_wr} = 2'h2;
    chk({core_reset_n_q, reset_cause_q}, 6'h01);
    wait_on(0);
    $display("test system reset done");
    for (int s = 0; s < 10; s++) begin
      rnd = lfsr(rnd);
      {clk_cfg_wr, osc_src_wdata} = {1'h1, s[1:0]};
      main_osc_en_wdata = rnd[0] || s[1:0] == 2'h0;
      {pll_skip_wdata, deep_sleep} = {s < 4, s > 7};
      cyc(2);
      chk(system_clock_src_q, s > 7 ? 3'h3 : s > 3 && s[1:0] == 2'h0 ? 3'h4 : s[1:0]);
      chk(pll_ref_main_q, s[1:0] == 2'h0 && s > 3 && s < 8);
      chk(main_osc_pwr_q, (rnd[0] || s[1:0] == 2'h0) && s < 8);
    end
    {clk_cfg_wr, deep_sleep, ldo_wr, ldo_regulator_voltage_adjust_wdata} = 7'h1A;
    cyc(1);
    ldo_regulator_voltage_adjust_wdata = 4'hB;
    cyc(1);
    ldo_wr = 1'h0;
    chk(regulator_voltage_adjust_q, 4'hA);
    {wdt_load, wdt_enable, wdt_reset_en} = {32'd20, 2'h3};
    wait_on(2);
    chk(core_reset_n_q, 1'h1);
    wait_on(1);
    chk(reset_cause_q[3], 1'h1);
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule
